// ==== src/sfd_pkg.sv ====
// Constants for the stall prevention and frequency detection supervisor.
// Assumes a 10 MHz control clock and an Avalon-MM master on the bus side.
package sfd_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [5:0] SFD_OFS_CTRL = 6'h00;
	localparam logic [5:0] SFD_OFS_ACCEL = 6'h04;
	localparam logic [5:0] SFD_OFS_DECEL_V = 6'h08;
	localparam logic [5:0] SFD_OFS_RUN_LVL = 6'h0c;
	localparam logic [5:0] SFD_OFS_PM_TIME = 6'h10;
	localparam logic [5:0] SFD_OFS_DETECT = 6'h14;
	localparam logic [5:0] SFD_OFS_LOSS = 6'h18;
	localparam logic [5:0] SFD_OFS_DECEL_T = 6'h1c;
	localparam logic [5:0] SFD_OFS_MAX_F = 6'h20;
	localparam logic [5:0] SFD_OFS_AIN_FN = 6'h24;
	localparam logic [5:0] SFD_OFS_DOUT_FN = 6'h28;
	localparam logic [5:0] SFD_OFS_BASE_F = 6'h2c;
	localparam logic [5:0] SFD_OFS_STATUS = 6'h30;
	// Control word field positions
	localparam int SFD_CTRL_ACCEL_EN = 0;
	localparam int SFD_CTRL_DECEL_EN = 1;
	localparam int SFD_CTRL_RUN_SEL = 2;
	localparam int SFD_CTRL_LOSS_SEL = 4;
	localparam int SFD_CTRL_PM = 5;
	// Reset values
	localparam logic [5:0] SFD_RST_CTRL = 6'h07;
	localparam logic [7:0] SFD_RST_ACCEL_LVL = 8'h96;
	localparam logic [7:0] SFD_RST_FLOOR = 8'h32;
	localparam logic [9:0] SFD_RST_DECEL_V = 10'h18b;
	localparam logic [7:0] SFD_RST_RUN_LVL = 8'h96;
	localparam logic [15:0] SFD_RST_PM_TIME = 16'h0000;
	localparam logic [15:0] SFD_RST_DET_LVL = 16'h012c;
	localparam logic [7:0] SFD_RST_DET_W = 8'h14;
	localparam logic [9:0] SFD_RST_FALLBACK = 10'h320;
	localparam logic [8:0] SFD_RST_WINDOW = 9'h014;
	localparam logic [15:0] SFD_RST_DECEL_T = 16'h0064;
	localparam logic [15:0] SFD_RST_MAX_F = 16'h0258;
	// Setting limits
	localparam logic [7:0] SFD_FLOOR_MAX = 8'h64;
	localparam logic [9:0] SFD_DECEL_V_MIN = 10'h14a;
	localparam logic [9:0] SFD_DECEL_V_MAX = 10'h19a;
	localparam logic [7:0] SFD_RUN_LVL_MIN = 8'h1e;
	localparam logic [7:0] SFD_RUN_LVL_MAX = 8'h96;
	localparam logic [7:0] SFD_DET_W_MIN = 8'h01;
	localparam logic [9:0] SFD_FALLBACK_MAX = 10'h3e8;
	localparam logic [8:0] SFD_WINDOW_MIN = 9'h014;
	localparam logic [8:0] SFD_WINDOW_MAX = 9'h190;
	// Comparison constants
	localparam logic [7:0] SFD_ACCEL_HYST = 8'h0f;
	localparam logic [7:0] SFD_RUN_HYST = 8'h02;
	localparam logic [15:0] SFD_RUN_MIN_FREQ = 16'h003c;
	localparam logic [4:0] SFD_AIN_FN_RUN_LVL = 5'h07;
	localparam logic [4:0] SFD_DO_AGREE = 5'h02;
	localparam logic [4:0] SFD_DO_USER_AGREE = 5'h03;
	localparam logic [4:0] SFD_DO_LOSS = 5'h09;
	localparam logic [4:0] SFD_DO_DETECT1 = 5'h10;
	localparam logic [4:0] SFD_DO_DETECT2 = 5'h11;
	localparam logic [3:0] SFD_LOSS_NUM = 4'h9;
	localparam logic [3:0] SFD_LOSS_DEN = 4'ha;
	// Timing: control tick of 1 ms, restore wait of 100 ms
	localparam int SFD_CLK_HZ = 10000000;
	localparam int SFD_TICK_US = 1000;
	localparam int SFD_TICK_CYCLES = SFD_CLK_HZ / 1000000 * SFD_TICK_US;
	localparam int SFD_RUN_WAIT_MS = 100;
	localparam logic [7:0] SFD_RUN_WAIT_TICKS = 8'(SFD_RUN_WAIT_MS * 1000 /
		SFD_TICK_US);
	// Run stall states
	typedef enum logic [1:0] {
		SFD_RS_IDLE,
		SFD_RS_REDUCE,
		SFD_RS_WAIT,
		SFD_RS_RECOVER
	} sfd_rs_state_t;
endpackage : sfd_pkg

// ==== src/sfd_supervisor.sv ====
// Stall prevention, frequency detection and command loss supervisor.
// Assumes synchronous measurement inputs and an Avalon-MM master.
// Units: current in % of rated, voltage in V, frequency and time in 0.1.
//
// The Avalon-MM register port and the register offsets were decided locally.
module sfd_supervisor import sfd_pkg::*; #(
	parameter int TICK_CYCLES = SFD_TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] out_current,
	input wire logic [9:0] bus_voltage,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] freq_cmd,
	input wire logic cmd_is_analog,
	input wire logic accelerating,
	input wire logic decelerating,
	input wire logic [7:0] analog_input_first,
	input wire logic [7:0] analog_input_second,
	input wire logic motor2_sel,
	input wire logic class_400v,
	output logic ramp_hold,
	output logic ramp_down,
	output logic ramp_recover,
	output logic [15:0] ramp_decel_time,
	output logic [15:0] freq_target,
	output logic [3:0] digital_out,
	output logic cmd_loss
);
	logic [5:0] ctrl;
	logic [7:0] accel_stall_level, accel_stall_floor;
	logic [9:0] decel_stall_voltage;
	logic [7:0] run_stall_current_level;
	logic [15:0] pm_stall_decel_time;
	logic [15:0] freq_detect_level;
	logic [7:0] freq_detect_width;
	logic [9:0] cmd_loss_fallback_pct;
	logic [8:0] cmd_loss_window;
	logic [15:0] decel_time_bank_one, decel_time_bank_two;
	logic [15:0] max_output_freq, motor2_max_output_freq;
	logic [15:0] base_freq;
	logic [4:0] ain_fn_first, ain_fn_second;
	logic [19:0] dout_fn;
	logic bus_ack;
	logic [31:0] rd_mux;
	logic [31:0] wmask;
	logic wr_go;
	logic [13:0] tick_cnt;
	logic tick;
	logic [7:0] cur_s;
	logic [9:0] vbus_s;
	logic [15:0] fout_s, fcmd_s;
	logic accel_hold, decel_hold;
	sfd_rs_state_t rs_state, next_rs_state;
	logic [7:0] rs_cnt;
	logic [7:0] accel_eff, run_eff, run_low;
	logic [9:0] decel_thr;
	logic [23:0] cp_scaled;
	logic [8:0] win_cnt;
	logic [15:0] loss_ref, hold_ref;
	logic [25:0] fallback_prod;
	logic det1, det2;
	logic agree, user_agree;
	logic [1:0] run_sel;

	// One wait state, then the request completes with registered read data
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
	assign wr_go = avs_write & bus_ack;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read | avs_write) & ~bus_ack;
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			SFD_OFS_CTRL: rd_mux = {26'h0, ctrl};
			SFD_OFS_ACCEL: rd_mux = {16'h0, accel_stall_floor, accel_stall_level};
			SFD_OFS_DECEL_V: rd_mux = {22'h0, decel_stall_voltage};
			SFD_OFS_RUN_LVL: rd_mux = {24'h0, run_stall_current_level};
			SFD_OFS_PM_TIME: rd_mux = {16'h0, pm_stall_decel_time};
			SFD_OFS_DETECT: rd_mux = {8'h0, freq_detect_width, freq_detect_level};
			SFD_OFS_LOSS: rd_mux = {7'h0, cmd_loss_window, 6'h0,
				cmd_loss_fallback_pct};
			SFD_OFS_DECEL_T: rd_mux = {decel_time_bank_two, decel_time_bank_one};
			SFD_OFS_MAX_F: rd_mux = {motor2_max_output_freq, max_output_freq};
			SFD_OFS_AIN_FN: rd_mux = {19'h0, ain_fn_second, 3'h0, ain_fn_first};
			SFD_OFS_DOUT_FN: rd_mux = {3'h0, dout_fn[19:15], 3'h0, dout_fn[14:10],
				3'h0, dout_fn[9:5], 3'h0, dout_fn[4:0]};
			SFD_OFS_BASE_F: rd_mux = {16'h0, base_freq};
			SFD_OFS_STATUS: rd_mux = {24'h0, digital_out, cmd_loss, accel_hold,
				decel_hold, rs_state != SFD_RS_IDLE};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~bus_ack) begin
			avs_readdata <= rd_mux;
		end
	end

	// Register writes with byte lanes; settings clamped to their ranges
	always_ff @(posedge ref_clk or negedge rstn) begin
		logic [31:0] w;
		if (!rstn) begin
			ctrl <= SFD_RST_CTRL;
			accel_stall_level <= SFD_RST_ACCEL_LVL;
			accel_stall_floor <= SFD_RST_FLOOR;
			decel_stall_voltage <= SFD_RST_DECEL_V;
			run_stall_current_level <= SFD_RST_RUN_LVL;
			pm_stall_decel_time <= SFD_RST_PM_TIME;
			freq_detect_level <= SFD_RST_DET_LVL;
			freq_detect_width <= SFD_RST_DET_W;
			cmd_loss_fallback_pct <= SFD_RST_FALLBACK;
			cmd_loss_window <= SFD_RST_WINDOW;
			decel_time_bank_one <= SFD_RST_DECEL_T;
			decel_time_bank_two <= SFD_RST_DECEL_T;
			max_output_freq <= SFD_RST_MAX_F;
			motor2_max_output_freq <= SFD_RST_MAX_F;
			base_freq <= SFD_RST_MAX_F;
			ain_fn_first <= 5'h00;
			ain_fn_second <= 5'h00;
			dout_fn <= 20'h00000;
		end else if (wr_go) begin
			w = (rd_mux & ~wmask) | (avs_writedata & wmask);
			case (avs_address)
				SFD_OFS_CTRL: begin
					ctrl <= w[5:0];
					if (w[3:2] == 2'b11) begin
						ctrl[3:2] <= 2'b10;
					end
				end
				SFD_OFS_ACCEL: begin
					accel_stall_level <= w[7:0];
					accel_stall_floor <= (w[15:8] > SFD_FLOOR_MAX) ? SFD_FLOOR_MAX :
						w[15:8];
				end
				SFD_OFS_DECEL_V: decel_stall_voltage <= (w[9:0] < SFD_DECEL_V_MIN) ?
					SFD_DECEL_V_MIN : (w[9:0] > SFD_DECEL_V_MAX) ? SFD_DECEL_V_MAX :
					w[9:0];
				SFD_OFS_RUN_LVL: run_stall_current_level <= (w[7:0] <
					SFD_RUN_LVL_MIN) ? SFD_RUN_LVL_MIN : (w[7:0] > SFD_RUN_LVL_MAX) ?
					SFD_RUN_LVL_MAX : w[7:0];
				SFD_OFS_PM_TIME: pm_stall_decel_time <= w[15:0];
				SFD_OFS_DETECT: begin
					freq_detect_level <= w[15:0];
					freq_detect_width <= (w[23:16] < SFD_DET_W_MIN) ? SFD_DET_W_MIN :
						w[23:16];
				end
				SFD_OFS_LOSS: begin
					cmd_loss_fallback_pct <= (w[9:0] > SFD_FALLBACK_MAX) ?
						SFD_FALLBACK_MAX : w[9:0];
					cmd_loss_window <= (w[24:16] < SFD_WINDOW_MIN) ? SFD_WINDOW_MIN :
						(w[24:16] > SFD_WINDOW_MAX) ? SFD_WINDOW_MAX :
						w[24:16];
				end
				SFD_OFS_DECEL_T: begin
					decel_time_bank_one <= w[15:0];
					decel_time_bank_two <= w[31:16];
				end
				SFD_OFS_MAX_F: begin
					max_output_freq <= w[15:0];
					motor2_max_output_freq <= w[31:16];
				end
				SFD_OFS_AIN_FN: begin
					ain_fn_first <= w[4:0];
					ain_fn_second <= w[12:8];
				end
				SFD_OFS_DOUT_FN: dout_fn <= {w[28:24], w[20:16], w[12:8], w[4:0]};
				SFD_OFS_BASE_F: base_freq <= w[15:0];
				default: ;
			endcase
		end
	end

	// Control tick divider
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 14'h0000;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 14'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 14'(TICK_CYCLES - 1)) ? 14'h0000 :
				tick_cnt + 14'h0001;
		end
	end

	// Measurement samples, taken once per tick
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cur_s <= 8'h00;
			vbus_s <= 10'h000;
			fout_s <= 16'h0000;
			fcmd_s <= 16'h0000;
		end else if (tick) begin
			cur_s <= out_current;
			vbus_s <= bus_voltage;
			fout_s <= out_freq;
			fcmd_s <= freq_cmd;
		end
	end

	// Effective thresholds
	always_comb begin
		cp_scaled = (24'(accel_stall_level) * 24'(base_freq)) / 24'(fout_s);
		accel_eff = accel_stall_level;
		if (fout_s > base_freq) begin
			accel_eff = (cp_scaled[7:0] < accel_stall_floor) ? accel_stall_floor :
				cp_scaled[7:0];
		end
		run_eff = run_stall_current_level;
		if (ain_fn_first == SFD_AIN_FN_RUN_LVL &&
			analog_input_first < run_eff) begin
			run_eff = analog_input_first;
		end
		if (ain_fn_second == SFD_AIN_FN_RUN_LVL &&
			analog_input_second < run_eff) begin
			run_eff = analog_input_second;
		end
		run_low = (run_eff > SFD_RUN_HYST) ? run_eff - SFD_RUN_HYST : 8'h00;
		decel_thr = class_400v ? {decel_stall_voltage[8:0], 1'b0} :
			decel_stall_voltage;
		run_sel = ctrl[SFD_CTRL_RUN_SEL +: 2];
	end

	// Acceleration stall hold with hysteresis
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			accel_hold <= 1'b0;
		end else if (tick) begin
			if (!ctrl[SFD_CTRL_ACCEL_EN] || !accelerating) begin
				accel_hold <= 1'b0;
			end else if (cur_s > accel_eff) begin
				accel_hold <= 1'b1;
			end else if ({1'b0, cur_s} + {1'b0, SFD_ACCEL_HYST} <
				{1'b0, accel_eff}) begin
				accel_hold <= 1'b0;
			end
		end
	end

	// Deceleration stall hold on bus voltage
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			decel_hold <= 1'b0;
		end else if (tick) begin
			if (!ctrl[SFD_CTRL_DECEL_EN] || !decelerating) begin
				decel_hold <= 1'b0;
			end else if (vbus_s > decel_thr) begin
				decel_hold <= 1'b1;
			end else if (vbus_s < decel_thr) begin
				decel_hold <= 1'b0;
			end
		end
	end

	// Run stall sequencer
	always_comb begin
		next_rs_state = rs_state;
		if (run_sel == 2'b00 || fout_s < SFD_RUN_MIN_FREQ) begin
			next_rs_state = SFD_RS_IDLE;
		end else begin
			case (rs_state)
				SFD_RS_IDLE: if (cur_s > run_eff) begin
					next_rs_state = SFD_RS_REDUCE;
				end
				SFD_RS_REDUCE: if (cur_s < run_low) begin
					next_rs_state = SFD_RS_WAIT;
				end
				SFD_RS_WAIT: begin
					if (cur_s > run_eff) begin
						next_rs_state = SFD_RS_REDUCE;
					end else if (rs_cnt == SFD_RUN_WAIT_TICKS) begin
						next_rs_state = SFD_RS_RECOVER;
					end
				end
				SFD_RS_RECOVER: begin
					if (cur_s > run_eff) begin
						next_rs_state = SFD_RS_REDUCE;
					end else if (fout_s >= fcmd_s) begin
						next_rs_state = SFD_RS_IDLE;
					end
				end
				default: next_rs_state = SFD_RS_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rs_state <= SFD_RS_IDLE;
			rs_cnt <= 8'h00;
		end else if (tick) begin
			rs_state <= next_rs_state;
			if (next_rs_state != SFD_RS_WAIT || cur_s >= run_low) begin
				rs_cnt <= 8'h00;
			end else if (rs_cnt != SFD_RUN_WAIT_TICKS) begin
				rs_cnt <= rs_cnt + 8'h01;
			end
		end
	end

	// Ramp commands to the ramp generator
	assign ramp_hold = (accel_hold & ~ctrl[SFD_CTRL_PM]) | decel_hold |
		(rs_state == SFD_RS_WAIT);
	assign ramp_down = (accel_hold & ctrl[SFD_CTRL_PM]) |
		(rs_state == SFD_RS_REDUCE);
	assign ramp_recover = (rs_state == SFD_RS_RECOVER);

	// Deceleration time in use for stall reductions
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ramp_decel_time <= SFD_RST_DECEL_T;
		end else if (accel_hold && ctrl[SFD_CTRL_PM]) begin
			ramp_decel_time <= (pm_stall_decel_time != 16'h0000) ?
				pm_stall_decel_time : decel_time_bank_one;
		end else if (run_sel == 2'b10) begin
			ramp_decel_time <= decel_time_bank_two;
		end else begin
			ramp_decel_time <= decel_time_bank_one;
		end
	end

	// Frequency detection with width as hysteresis
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			det1 <= 1'b0;
			det2 <= 1'b0;
		end else if (tick) begin
			if (fout_s <= freq_detect_level) begin
				det1 <= 1'b1;
			end else if ({1'b0, fout_s} > {1'b0, freq_detect_level} +
				{9'h000, freq_detect_width}) begin
				det1 <= 1'b0;
			end
			if (fout_s >= freq_detect_level) begin
				det2 <= 1'b1;
			end else if ({1'b0, fout_s} + {9'h000, freq_detect_width} <
				{1'b0, freq_detect_level}) begin
				det2 <= 1'b0;
			end
		end
	end

	always_comb begin
		agree = ((fout_s > fcmd_s) ? fout_s - fcmd_s : fcmd_s - fout_s) <=
			{8'h00, freq_detect_width};
		user_agree = agree && (((fout_s > freq_detect_level) ?
			fout_s - freq_detect_level : freq_detect_level - fout_s) <=
			{8'h00, freq_detect_width});
	end

	// Multi-function outputs by configured code
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			digital_out <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				case (dout_fn[i*5 +: 5])
					SFD_DO_AGREE: digital_out[i] <= agree;
					SFD_DO_USER_AGREE: digital_out[i] <= user_agree;
					SFD_DO_DETECT1: digital_out[i] <= det1;
					SFD_DO_DETECT2: digital_out[i] <= det2;
					SFD_DO_LOSS: digital_out[i] <= cmd_loss;
					default: digital_out[i] <= 1'b0;
				endcase
			end
		end
	end

	// Command loss: compare against the value at the start of each window
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			win_cnt <= 9'h000;
			hold_ref <= 16'h0000;
			loss_ref <= 16'h0000;
			cmd_loss <= 1'b0;
		end else if (tick) begin
			if (!cmd_is_analog) begin
				cmd_loss <= 1'b0;
				win_cnt <= 9'h000;
				hold_ref <= fcmd_s;
			end else if (cmd_loss) begin
				if (20'(fcmd_s) * 20'(SFD_LOSS_DEN) >=
					20'(loss_ref) * 20'(SFD_LOSS_NUM)) begin
					cmd_loss <= 1'b0;
					hold_ref <= fcmd_s;
					win_cnt <= 9'h000;
				end
			end else if (20'(fcmd_s) * 20'(SFD_LOSS_DEN) <
				20'(hold_ref) * 20'(SFD_LOSS_NUM)) begin
				cmd_loss <= 1'b1;
				loss_ref <= hold_ref;
			end else if (win_cnt >= cmd_loss_window - 9'h001) begin
				win_cnt <= 9'h000;
				hold_ref <= fcmd_s;
			end else begin
				win_cnt <= win_cnt + 9'h001;
			end
		end
	end

	// Frequency target: fallback only with loss select 1
	always_comb begin
		fallback_prod = 26'(motor2_sel ? motor2_max_output_freq :
			max_output_freq) * 26'(cmd_loss_fallback_pct) / 26'd1000;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			freq_target <= 16'h0000;
		end else if (cmd_loss && ctrl[SFD_CTRL_LOSS_SEL]) begin
			freq_target <= fallback_prod[15:0];
		end else begin
			freq_target <= freq_cmd;
		end
	end
endmodule : sfd_supervisor

// ==== sim/sfd_checker_sva.sv ====
// Port checks for the stall and frequency supervisor.
// Assumes the bind below and a bus master that holds each request.
module sfd_checker import sfd_pkg::*; #(
	parameter int TICK_CYCLES = SFD_TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] freq_cmd,
	input wire logic cmd_is_analog,
	input wire logic ramp_recover,
	input wire logic [15:0] ramp_decel_time,
	input wire logic [15:0] freq_target,
	input wire logic cmd_loss
);
	int low_cnt;
	// Cycles spent below the run stall floor frequency
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= (out_freq < SFD_RUN_MIN_FREQ) ? low_cnt + 1 : 0;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	bus_wait_a: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest) else $error("no wait state on new request");
	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait state too long");
	idle_wait_a: assert property (!(avs_read || avs_write) |->
		!avs_waitrequest) else $error("waitrequest while idle");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	target_cmd_a: assert property (!cmd_loss ##1 !cmd_loss |->
		freq_target == $past(freq_cmd)) else $error("target not command");
	low_freq_a: assert property (low_cnt > 4 * TICK_CYCLES |->
		!ramp_recover) else $error("run stall active at low frequency");
	loss_src_a: assert property ($rose(cmd_loss) |-> cmd_is_analog)
		else $error("command loss without analog command");
	rst_vals_a: assert property ($rose(rstn) |-> !cmd_loss &&
		ramp_decel_time == SFD_RST_DECEL_T) else $error("bad reset outputs");
endmodule : sfd_checker
bind sfd_supervisor sfd_checker #(.TICK_CYCLES(TICK_CYCLES)) u_sfd_checker (
	.*);

// ==== sim/sfd_drive_model.sv ====
// Ramp generator and measurement path facing the supervisor.
// Assumes the bench sets load levels; frequency steps once per tick.
module sfd_drive_model #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ramp_hold,
	input wire logic ramp_down,
	input wire logic ramp_recover,
	input wire logic load_freq,
	input wire logic [15:0] new_freq,
	input wire logic [7:0] set_current,
	input wire logic [9:0] set_voltage,
	output logic [15:0] out_freq,
	output logic [7:0] out_current,
	output logic [9:0] bus_voltage
);
	int tick_cnt;
	// Measurements follow the load one clock late
	always_ff @(posedge ref_clk) begin
		out_current <= set_current;
		bus_voltage <= set_voltage;
	end
	// Frequency obeys ramp requests once per tick unless pinned
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 0;
			out_freq <= 16'h0000;
		end else begin
			tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 0 : tick_cnt + 1;
			if (load_freq) begin
				out_freq <= new_freq;
			end else if (tick_cnt == 0 && !ramp_hold) begin
				if (ramp_down) begin
					out_freq <= out_freq - 16'h0001;
				end else if (ramp_recover) begin
					out_freq <= out_freq + 16'h0001;
				end
			end
		end
	end
endmodule : sfd_drive_model

// ==== sim/test_stall_prevention_freq_detect.sv ====
// Self-checking bench for the stall and frequency supervisor.
// Assumes the drive model beside it and a 20-cycle control tick.
module test_stall_prevention_freq_detect import sfd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 20;
	localparam logic [5:0] RA[11] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10,
		6'h14, 6'h18, 6'h1c, 6'h20, 6'h2c, 6'h34};
	localparam logic [31:0] RV[11] = '{32'h7, 32'h3296, 32'h18b, 32'h96,
		32'h0, 32'h14012c, 32'h140320, 32'h640064, 32'h2580258, 32'h258, 32'h0};
	localparam logic [5:0] WA[9] = '{6'h08, 6'h08, 6'h0c, 6'h0c, 6'h04,
		6'h18, 6'h14, 6'h00, 6'h34};
	localparam logic [31:0] WD[9] = '{32'h0, 32'h3ff, 32'h5, 32'hff,
		32'hff96, 32'h1ff03ff, 32'h12c, 32'hf, 32'h1234};
	localparam logic [31:0] WV[9] = '{32'h14a, 32'h19a, 32'h1e, 32'h96,
		32'h6496, 32'h19003e8, 32'h1012c, 32'hb, 32'h0};
	logic ref_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, got, pword, rv;
	logic avs_waitrequest, ramp_hold, ramp_down, ramp_recover, cmd_loss;
	logic cmd_is_analog = 1'b0, accelerating = 1'b0, decelerating = 1'b0;
	logic class_400v = 1'b0;
	logic motor2_sel = 1'b0, load_freq = 1'b1, probe_go = 1'b0;
	logic [15:0] out_freq, freq_cmd = 16'h0, new_freq = 16'h12c;
	logic [15:0] ramp_decel_time, freq_target;
	logic [7:0] out_current, set_current = 8'h0, analog_input_first = 8'hff;
	logic [9:0] bus_voltage, set_voltage = 10'h12c;
	logic [3:0] digital_out;
	logic [31:0] exp_q[$], msk_q[$];
	int err_total = 0, num_checks = 0, cycles = 0;
	sfd_supervisor #(.TICK_CYCLES(TK)) u_sfd_supervisor (.*,
		.avs_byteenable(4'hf), .analog_input_second(8'hff));
	sfd_drive_model #(.TICK_CYCLES(TK)) u_sfd_drive_model (.*);
	// Probe word: target, decel time, hold, down, recover, loss
	assign pword = {freq_target, ramp_decel_time[11:0], ramp_hold, ramp_down,
		ramp_recover, cmd_loss};
	// Clock and run-length guard
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	// Compare each finished read or probe with the oldest note
	always @(negedge ref_clk) begin
		if ((avs_read && avs_waitrequest === 1'b0) || probe_go) begin
			got = probe_go ? pword : avs_readdata;
			num_checks++;
			if ((got & msk_q[0]) !== exp_q[0]) begin
				err_total++;
				$display("wrong value at %0t: got %h", $time, got);
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic w(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : w
	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rd(6'h30, e, m);
	endtask : st
	task automatic pr(input logic [31:0] e, input logic [31:0] m);
		@(posedge ref_clk);
		exp_q.push_back(e);
		msk_q.push_back(m);
		probe_go <= 1'b1;
		@(posedge ref_clk);
		probe_go <= 1'b0;
	endtask : pr
	task automatic tk(input int n);
		repeat (n * TK) @(posedge ref_clk);
	endtask : tk
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		void'($urandom(32248));
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		foreach (RA[i]) rd(RA[i], RV[i]);
		foreach (WA[i]) begin
			w(WA[i], WD[i]);
			rd(WA[i], WV[i]);
		end
		rv = 32'($urandom_range(150, 30));
		w(6'h0c, rv);
		rd(6'h0c, rv);
		w(6'h0c, 32'h96);
		w(6'h14, 32'h14012c);
		w(6'h18, 32'h140320);
		w(6'h1c, 32'hc80032);
		w(6'h28, 32'h11100203);
		w(6'h00, 32'h7);
		// Decel hold around 410 V, repeated
		decelerating <= 1'b1;
		repeat (2) begin
			set_voltage <= 10'h1a4;
			tk(4);
			st(32'h2, 32'h2);
			pr(32'h8, 32'h8);
			set_voltage <= 10'h190;
			tk(4);
			st(32'h0, 32'h2);
		end
		w(6'h00, 32'h5);
		set_voltage <= 10'h1a4;
		tk(4);
		st(32'h0, 32'h2);
		class_400v <= 1'b1;
		w(6'h00, 32'h7);
		tk(4);
		st(32'h0, 32'h2);
		set_voltage <= 10'h348;
		tk(4);
		st(32'h2, 32'h2);
		class_400v <= 1'b0;
		decelerating <= 1'b0;
		w(6'h00, 32'h7);
		// Run stall on bank one, then bank two, then the restore wait
		freq_cmd <= 16'h190;
		load_freq <= 1'b0;
		set_current <= 8'ha0;
		tk(4);
		st(32'h1, 32'h1);
		pr(32'h324, 32'hfff4);
		w(6'h00, 32'hb);
		tk(2);
		pr(32'hc84, 32'hfff4);
		set_current <= 8'h8c;
		tk(90);
		pr(32'h0, 32'h6);
		tk(16);
		pr(32'h2, 32'h6);
		load_freq <= 1'b1;
		new_freq <= 16'h32;
		set_current <= 8'ha0;
		tk(6);
		st(32'h0, 32'h1);
		new_freq <= 16'h12c;
		w(6'h00, 32'h3);
		tk(4);
		st(32'h0, 32'h1);
		set_current <= 8'h78;
		w(6'h24, 32'h7);
		analog_input_first <= 8'h64;
		w(6'h00, 32'h7);
		tk(4);
		st(32'h1, 32'h1);
		// Accel hold with its 15 point release band
		w(6'h00, 32'h3);
		accelerating <= 1'b1;
		set_current <= 8'ha0;
		tk(4);
		st(32'h4, 32'h4);
		set_current <= 8'h8c;
		tk(4);
		st(32'h4, 32'h4);
		set_current <= 8'h82;
		tk(4);
		st(32'h0, 32'h4);
		// Constant power range lowers the level to 90 with a floor of 50
		w(6'h04, 32'h3296);
		new_freq <= 16'h3e8;
		set_current <= 8'h5f;
		tk(4);
		st(32'h4, 32'h4);
		set_current <= 8'h46;
		tk(4);
		st(32'h0, 32'h4);
		new_freq <= 16'h12c;
		// PM motor: own stall decel time, bank one when it is zero
		w(6'h10, 32'h7b);
		w(6'h00, 32'h23);
		set_current <= 8'ha0;
		tk(4);
		pr(32'h7b4, 32'hfffc);
		w(6'h10, 32'h0);
		tk(1);
		pr(32'h324, 32'hfffc);
		accelerating <= 1'b0;
		// Agree and detect outputs at 30.0 Hz and at 34.0 Hz
		set_current <= 8'h0;
		freq_cmd <= 16'h12c;
		tk(4);
		st(32'hf0, 32'hf0);
		new_freq <= 16'h154;
		tk(4);
		st(32'h80, 32'hf0);
		w(6'h28, 32'h11100209);
		// Command loss with fallback, motor two maximum frequency, then without
		freq_cmd <= 16'h1f4;
		cmd_is_analog <= 1'b1;
		w(6'h00, 32'h17);
		tk(60);
		freq_cmd <= 16'h64;
		tk(25);
		pr(32'h1e00001, 32'hffff0001);
		st(32'h18, 32'h18);
		w(6'h20, 32'h1900258);
		motor2_sel <= 1'b1;
		tk(2);
		pr(32'h1400001, 32'hffff0001);
		freq_cmd <= 16'h1f4;
		tk(5);
		pr(32'h1f40000, 32'hffff0001);
		motor2_sel <= 1'b0;
		w(6'h00, 32'h7);
		tk(60);
		freq_cmd <= 16'h64;
		tk(25);
		pr(32'h640001, 32'hffff0001);
		finish_test();
	end
endmodule : test_stall_prevention_freq_detect
